/* File: hw/pdm_defs.svh */
// Offsets, field positions, reset values and fixed addresses of the
// memory map block. Definitions only; included by the block's files.
`ifndef PDM_DEFS_SVH
`define PDM_DEFS_SVH

// ----------------------------------------
// Program space
// ----------------------------------------
`define PDM_RESET_VEC  16'h0000
`define PDM_VEC_STEP   16'h0008
`define PDM_UNDEF_WORD 16'hffff
`define PDM_CFG_UNPROG 2'b11

// ----------------------------------------
// Bus control pins: [0] latch, [1] read low, [2] write low
// ----------------------------------------
`define PDM_CTL_ALE  0
`define PDM_CTL_OE   1
`define PDM_CTL_IDLE 3'b110
`define PDM_CTL_ADDR 3'b111
`define PDM_CTL_DATA 3'b100

// ----------------------------------------
// Data memory map
// ----------------------------------------
`define PDM_A_INDF0   8'h00
`define PDM_A_FP0     8'h01
`define PDM_A_INDF1   8'h08
`define PDM_A_FP1     8'h09
`define PDM_A_BSR     8'h0f
`define PDM_A_SFR_LO  8'h10
`define PDM_A_SFR_HI  8'h17
`define PDM_A_URAM_LO 8'h1a
`define PDM_A_URAM_HI 8'h1f
`define PDM_A_GRAM_LO 8'h20
`define PDM_URAM_N    12'd6
`define PDM_GRAM_N    12'd224
`define PDM_BSR_RST   8'h00
`define PDM_FP_RST    8'h00

`endif

/* File: hw/pdm_pkg.sv */
// Types of the memory map block: modes, bus states, location and state.
// Offsets and reset values live in pdm_defs.svh.
package pdm_pkg;

  typedef enum logic [1:0] {
    PDM_PROT = 2'b00,
    PDM_CTRL = 2'b01,
    PDM_EXT  = 2'b10,
    PDM_PROC = 2'b11
  } pdm_mode_e;

  typedef enum logic [2:0] {
    BUS_IDLE = 3'b001,
    BUS_ADDR = 3'b010,
    BUS_DATA = 3'b100
  } pdm_bus_e;

  typedef enum logic [2:0] {
    PDM_K_NONE = 3'd0,
    PDM_K_RAM  = 3'd1,
    PDM_K_SFR  = 3'd2,
    PDM_K_FP0  = 3'd3,
    PDM_K_FP1  = 3'd4,
    PDM_K_BSR  = 3'd5
  } pdm_kind_e;

  typedef struct packed {
    pdm_kind_e   kind;
    logic [3:0]  bank;
    logic [11:0] idx;
  } pdm_loc_s;

  typedef struct packed {
    pdm_mode_e   mode;
    logic        code_prot;
    logic        int_ok;
    logic        spec_ok;
    logic [15:0] pc;
    pdm_bus_e    bus;
    logic [15:0] faddr;
    logic        fint;
    logic [15:0] fdata;
    logic        fvalid;
    logic [7:0]  bus_lo;
    logic [7:0]  bus_hi;
    logic        bus_oe;
    logic [2:0]  ctl;
    logic        ctl_oe;
    logic [7:0]  bank_select_reg;
    logic [7:0]  fp0;
    logic [7:0]  fp1;
    logic [7:0]  rdata;
    logic        rvalid;
    logic        per_we;
    logic [3:0]  per_bank;
    logic [2:0]  per_addr;
    logic [7:0]  per_wdata;
  } pdm_state_s;

endpackage

/* File: hw/pdm_prog_mem.sv */
// Internal program memory array with a programming write port.
// Assumes writes come only from the programming path of the top.
`timescale 1ns/1ps
`default_nettype none
`include "pdm_defs.svh"

module pdm_prog_mem #(
  parameter int WORDS = 8192
) (
  input  wire logic        i_mclk,
  input  wire logic        i_wr,
  input  wire logic [15:0] i_waddr,
  input  wire logic [15:0] i_wdata,
  input  wire logic [15:0] i_raddr,
  output logic      [15:0] o_rdata
);
  localparam int          AW    = $clog2(WORDS);
  localparam logic [16:0] LIMIT = 17'(WORDS);

  logic [15:0] mem [WORDS];

  always_ff @(posedge i_mclk) begin
    if (i_wr && ({1'b0, i_waddr} < LIMIT)) begin
      mem[i_waddr[AW-1:0]] <= i_wdata;
    end
  end

  // Nothing is implemented above the limit, so a fixed pattern answers
  always_comb begin
    o_rdata = `PDM_UNDEF_WORD;
    if ({1'b0, i_raddr} < LIMIT) begin
      o_rdata = mem[i_raddr[AW-1:0]];
    end
  end

endmodule // pdm_prog_mem
`default_nettype wire

/* File: hw/pdm_data_ram.sv */
// General purpose data RAM: asynchronous read, synchronous write.
// Assumes the top resolves banks into a flat index.
`timescale 1ns/1ps
`default_nettype none

module pdm_data_ram #(
  parameter int DEPTH = 902,
  parameter int AW    = 10
) (
  input  wire logic          i_mclk,
  input  wire logic          i_we,
  input  wire logic [AW-1:0] i_waddr,
  input  wire logic [7:0]    i_wdata,
  input  wire logic [AW-1:0] i_raddr,
  output logic      [7:0]    o_rdata
);
  logic [7:0] mem [DEPTH];

  // No reset on purpose: contents survive every reset source
  always_ff @(posedge i_mclk) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
  end

  assign o_rdata = mem[i_raddr];

endmodule // pdm_data_ram
`default_nettype wire

/* File: hw/pdm_memory_map.sv */
// Program and data memory map of an 8-bit core: fetch steering by mode,
// external multiplexed fetch bus, data memory bank decode.
// Assumes one core clock, synchronous inputs and at most one data
// operation from the core per cycle.
`timescale 1ns/1ps
`default_nettype none
`include "pdm_defs.svh"

// Behaviour
// - 16-bit counter over 64K x 16 words
// - Start at zero; four fixed interrupt vectors
// - Four program modes from configuration bits
// - Controller modes never drive external fetch
// - Beyond internal memory reads undefined data
// - Protected mode enables code protection
// - Extended mode switches internal/external by address
// - Processor mode fetches everything externally
// - Unprogrammed configuration gives processor mode
// - Area access permitted per mode
// - External modes make ports a multiplexed bus
// - Extended internal fetch mirrors strobes, ignores data
// - Data memory never goes on external bus
// - Unbanked accesses ignore bank select register
// - Moves between peripheral and file ranges
// - Indirect accesses apply bank bits too
// - 8-bit general RAM, banked beyond 230 bytes
// - General RAM never cleared by reset
// - Separate loads for peripheral and RAM banks
// - Special registers 10h-17h use low nibble
// - RAM 20h-FFh uses high nibble
// - Unimplemented data registers read zero
module pdm_memory_map
  import pdm_pkg::*;
#(
  parameter int PM_WORDS  = 8192,
  parameter int GPR_BANKS = 4,
  parameter int PER_BANKS = 9
) (
  input  wire logic        i_mclk,
  input  wire logic        i_sys_rst,
  input  wire logic [1:0]  i_cfg_mode,
  input  wire logic        i_fetch_req,
  input  wire logic        i_pc_load,
  input  wire logic [15:0] i_pc_value,
  input  wire logic        i_vec_take,
  input  wire logic [1:0]  i_vec_sel,
  output logic      [15:0] o_pc,
  output logic             o_fetch_busy,
  output logic             o_fetch_valid,
  output logic      [15:0] o_fetch_data,
  output logic             o_code_protect,
  output logic             o_int_pm_ok,
  output logic             o_special_ok,
  input  wire logic        i_pm_wr,
  input  wire logic [15:0] i_pm_waddr,
  input  wire logic [15:0] i_pm_wdata,
  input  wire logic [7:0]  i_bus_port_low,
  input  wire logic [7:0]  i_bus_port_high,
  output logic      [7:0]  o_bus_port_low,
  output logic      [7:0]  o_bus_port_high,
  output logic             o_bus_port_oe,
  output logic      [2:0]  o_bus_control_port,
  output logic             o_bus_control_oe,
  input  wire logic        i_dm_rd,
  input  wire logic        i_dm_wr,
  input  wire logic [7:0]  i_dm_addr,
  input  wire logic [7:0]  i_dm_wdata,
  input  wire logic        i_move_periph_to_file,
  input  wire logic        i_move_file_to_periph,
  input  wire logic [4:0]  i_p_addr,
  input  wire logic [7:0]  i_f_addr,
  input  wire logic        i_load_periph_bank,
  input  wire logic        i_load_ram_bank,
  input  wire logic [3:0]  i_lit,
  output logic      [7:0]  o_dm_rdata,
  output logic             o_dm_rvalid,
  output logic      [7:0]  o_bank_select_reg,
  input  wire logic [7:0]  i_per_rdata,
  output logic             o_per_we,
  output logic      [3:0]  o_per_bank,
  output logic      [2:0]  o_per_addr,
  output logic      [7:0]  o_per_wdata
);
  // ----------------------------------------
  // Sizes
  // ----------------------------------------
  localparam int          RAM_DEPTH = 6 + GPR_BANKS * 224;
  localparam int          RAM_AW    = $clog2(RAM_DEPTH);
  localparam logic [16:0] PM_LIM    = 17'(PM_WORDS);
  localparam logic [4:0]  PER_LIM   = 5'(PER_BANKS);
  localparam logic [4:0]  GPR_LIM   = 5'(GPR_BANKS);

  pdm_state_s  st;
  pdm_state_s  next_st;
  pdm_loc_s    src;
  pdm_loc_s    dst;
  logic [15:0] pm_addr;
  logic [15:0] pm_rdata;
  logic [7:0]  ram_rd;
  logic        ram_we;
  logic [7:0]  src_val;
  logic [7:0]  wval;
  logic [7:0]  src_a;
  logic [7:0]  dst_a;
  logic        do_wr;
  logic        ext_bus;
  logic        int_hit;

  // ----------------------------------------
  // Data address decode
  // ----------------------------------------
  function automatic pdm_loc_s pdm_locate(input logic [7:0] a_in,
                                          input logic [7:0] bank_select_reg,
                                          input logic [7:0] fp0,
                                          input logic [7:0] fp1);
    logic [7:0] a;
    pdm_loc_s   r;
    a = a_in;
    r = '0;
    r.kind = PDM_K_NONE;
    // A pointer aimed at an indirect slot lands on nothing
    if (a == `PDM_A_INDF0) begin
      a = fp0;
    end else if (a == `PDM_A_INDF1) begin
      a = fp1;
    end
    if (a == `PDM_A_FP0) begin
      r.kind = PDM_K_FP0;
    end else if (a == `PDM_A_FP1) begin
      r.kind = PDM_K_FP1;
    end else if (a == `PDM_A_BSR) begin
      r.kind = PDM_K_BSR;
    end else if (a >= `PDM_A_SFR_LO && a <= `PDM_A_SFR_HI) begin
      if ({1'b0, bank_select_reg[3:0]} < PER_LIM) begin
        r.kind = PDM_K_SFR;
        r.bank = bank_select_reg[3:0];
        r.idx  = {9'h000, a[2:0]};
      end
    end else if (a >= `PDM_A_URAM_LO && a <= `PDM_A_URAM_HI) begin
      r.kind = PDM_K_RAM;
      r.idx  = {4'h0, 8'(a - `PDM_A_URAM_LO)};
    end else if (a >= `PDM_A_GRAM_LO) begin
      if ({1'b0, bank_select_reg[7:4]} < GPR_LIM) begin
        r.kind = PDM_K_RAM;
        r.idx  = `PDM_URAM_N + {8'h00, bank_select_reg[7:4]} * `PDM_GRAM_N
               + {4'h0, 8'(a - `PDM_A_GRAM_LO)};
      end
    end
    return r;
  endfunction

  // ----------------------------------------
  // Memories
  // ----------------------------------------
  pdm_prog_mem #(
    .WORDS   (PM_WORDS)
  ) u_prog_mem (
    .i_mclk  (i_mclk),
    .i_wr    (i_pm_wr && !st.code_prot),
    .i_waddr (i_pm_waddr),
    .i_wdata (i_pm_wdata),
    .i_raddr (pm_addr),
    .o_rdata (pm_rdata)
  );

  pdm_data_ram #(
    .DEPTH   (RAM_DEPTH),
    .AW      (RAM_AW)
  ) u_data_ram (
    .i_mclk  (i_mclk),
    .i_we    (ram_we),
    .i_waddr (dst.idx[RAM_AW-1:0]),
    .i_wdata (wval),
    .i_raddr (src.idx[RAM_AW-1:0]),
    .o_rdata (ram_rd)
  );

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    next_st = st;
    next_st.fvalid = 1'b0;
    next_st.rvalid = 1'b0;
    next_st.per_we = 1'b0;
    ext_bus = (st.mode == PDM_PROC) || (st.mode == PDM_EXT);
    int_hit = (st.mode == PDM_CTRL) || (st.mode == PDM_PROT)
           || (st.mode == PDM_EXT && {1'b0, st.pc} < PM_LIM);
    pm_addr = (st.bus == BUS_IDLE) ? st.pc : st.faddr;
    next_st.code_prot = (st.mode == PDM_PROT);
    next_st.int_ok = (st.mode != PDM_PROC);
    next_st.spec_ok = (st.mode == PDM_CTRL) || (st.mode == PDM_PROT);
    next_st.ctl_oe = ext_bus;
    case (st.bus)
      BUS_IDLE: begin
        if (i_fetch_req) begin
          next_st.faddr = st.pc;
          next_st.fint = int_hit;
          next_st.pc = st.pc + 16'h0001;
          if (ext_bus) begin
            // Strobes run even for internal words in extended mode
            next_st.bus = BUS_ADDR;
            next_st.bus_lo = st.pc[7:0];
            next_st.bus_hi = st.pc[15:8];
            next_st.bus_oe = 1'b1;
            next_st.ctl = `PDM_CTL_ADDR;
          end else begin
            next_st.fdata = pm_rdata;
            next_st.fvalid = 1'b1;
          end
        end
      end
      BUS_ADDR: begin
        // Release the pins on the same edge that the read strobe lets the memory drive them
        next_st.bus = BUS_DATA;
        next_st.bus_oe = 1'b0;
        next_st.ctl = `PDM_CTL_DATA;
      end
      BUS_DATA: begin
        next_st.bus = BUS_IDLE;
        next_st.ctl = `PDM_CTL_IDLE;
        next_st.fvalid = 1'b1;
        if (st.fint) begin
          next_st.fdata = pm_rdata;
        end else begin
          next_st.fdata = {i_bus_port_high, i_bus_port_low};
        end
      end
      default: begin
        next_st.bus = BUS_IDLE;
        next_st.bus_oe = 1'b0;
        next_st.ctl = `PDM_CTL_IDLE;
      end
    endcase
    if (i_vec_take) begin
      next_st.pc = `PDM_VEC_STEP + {11'h000, i_vec_sel, 3'h0};
    end else if (i_pc_load) begin
      next_st.pc = i_pc_value;
    end

    // Data side stays on chip: only the RAM, file pointers, bank select register and peripheral port see it
    src_a = i_dm_addr;
    dst_a = i_dm_addr;
    if (i_move_periph_to_file) begin
      src_a = {3'h0, i_p_addr};
      dst_a = i_f_addr;
    end else if (i_move_file_to_periph) begin
      src_a = i_f_addr;
      dst_a = {3'h0, i_p_addr};
    end
    src = pdm_locate(src_a, st.bank_select_reg, st.fp0, st.fp1);
    dst = pdm_locate(dst_a, st.bank_select_reg, st.fp0, st.fp1);
    case (src.kind)
      PDM_K_RAM: src_val = ram_rd;
      PDM_K_SFR: src_val = i_per_rdata;
      PDM_K_FP0: src_val = st.fp0;
      PDM_K_FP1: src_val = st.fp1;
      PDM_K_BSR: src_val = st.bank_select_reg;
      default:   src_val = 8'h00;
    endcase
    do_wr = i_dm_wr || i_move_periph_to_file || i_move_file_to_periph;
    wval = i_dm_wr ? i_dm_wdata : src_val;
    ram_we = do_wr && (dst.kind == PDM_K_RAM);
    if (do_wr) begin
      case (dst.kind)
        PDM_K_SFR: begin
          next_st.per_we = 1'b1;
          next_st.per_bank = dst.bank;
          next_st.per_addr = dst.idx[2:0];
          next_st.per_wdata = wval;
        end
        PDM_K_FP0: next_st.fp0 = wval;
        PDM_K_FP1: next_st.fp1 = wval;
        PDM_K_BSR: next_st.bank_select_reg = wval;
        default: begin
        end
      endcase
    end
    if (i_load_periph_bank) begin
      next_st.bank_select_reg[3:0] = i_lit;
    end
    if (i_load_ram_bank) begin
      next_st.bank_select_reg[7:4] = i_lit;
    end
    if (i_dm_rd) begin
      next_st.rdata = src_val;
      next_st.rvalid = 1'b1;
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  // Mode is caught while reset is held, so it follows the bits then
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      st <= '0;
      st.mode <= pdm_mode_e'(i_cfg_mode);
      st.code_prot <= (i_cfg_mode == PDM_PROT);
      st.int_ok <= (i_cfg_mode != PDM_PROC);
      st.spec_ok <= (i_cfg_mode[1] == 1'b0);
      st.ctl_oe <= i_cfg_mode[1];
      st.pc <= `PDM_RESET_VEC;
      st.bus <= BUS_IDLE;
      st.ctl <= `PDM_CTL_IDLE;
      st.bank_select_reg <= `PDM_BSR_RST;
      st.fp0 <= `PDM_FP_RST;
      st.fp1 <= `PDM_FP_RST;
    end else begin
      st <= next_st;
    end
  end

  assign o_pc               = st.pc;
  assign o_fetch_busy       = ~st.bus[0];
  assign o_fetch_valid      = st.fvalid;
  assign o_fetch_data       = st.fdata;
  assign o_code_protect     = st.code_prot;
  assign o_int_pm_ok        = st.int_ok;
  assign o_special_ok       = st.spec_ok;
  assign o_bus_port_low     = st.bus_lo;
  assign o_bus_port_high    = st.bus_hi;
  assign o_bus_port_oe      = st.bus_oe;
  assign o_bus_control_port = st.ctl;
  assign o_bus_control_oe   = st.ctl_oe;
  assign o_dm_rdata         = st.rdata;
  assign o_dm_rvalid        = st.rvalid;
  assign o_bank_select_reg  = st.bank_select_reg;
  assign o_per_we           = st.per_we;
  assign o_per_bank         = st.per_bank;
  assign o_per_addr         = st.per_addr;
  assign o_per_wdata        = st.per_wdata;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_sys_rst);

  a_pc_reset_zero: assert property ($past(i_sys_rst) |-> o_pc == 16'h0000)
    else $error("pc not zero after reset");
  a_vec_target: assert property (i_vec_take |=>
      o_pc == 16'h0008 + {11'h000, $past(i_vec_sel), 3'h0})
    else $error("wrong interrupt vector");
  a_pc_step: assert property (i_fetch_req && st.bus == BUS_IDLE
      && !i_vec_take && !i_pc_load |=> o_pc == $past(o_pc) + 16'h0001)
    else $error("pc did not advance by one");
  a_ctrl_no_bus: assert property (st.mode == PDM_CTRL || st.mode == PDM_PROT
      |-> !o_bus_port_oe && !o_bus_control_oe)
    else $error("bus driven in controller mode");
  a_prot_flag: assert property (o_code_protect == (st.mode == PDM_PROT))
    else $error("code protect does not follow mode");
  a_unprog_mode: assert property ($past(i_sys_rst)
      && $past(i_cfg_mode) == 2'b11 |-> st.mode == PDM_PROC)
    else $error("unprogrammed part not in processor mode");
  a_area_access: assert property (o_special_ok == (st.mode[1] == 1'b0)
      && o_int_pm_ok == (st.mode != PDM_PROC))
    else $error("area access flags wrong for mode");
  a_bus_cycle: assert property (st.bus == BUS_IDLE && i_fetch_req
      && st.mode[1] |=> o_bus_port_oe && o_bus_control_port[0]
      ##1 !o_bus_port_oe && !o_bus_control_port[1] ##1 o_fetch_valid)
    else $error("external fetch sequence broken");
  a_proc_external: assert property (st.bus == BUS_DATA
      && st.mode == PDM_PROC |=> o_fetch_data
      == $past({i_bus_port_high, i_bus_port_low}))
    else $error("processor mode word not from bus");
  a_ext_internal: assert property (st.bus == BUS_DATA && st.fint
      |=> o_fetch_data == $past(pm_rdata))
    else $error("internal word not used in extended mode");
  a_ram_bank_load: assert property (i_load_ram_bank
      |=> o_bank_select_reg[7:4] == $past(i_lit))
    else $error("ram bank load lost");
  a_unimpl_zero: assert property (i_dm_rd && src.kind == PDM_K_NONE
      |=> o_dm_rvalid && o_dm_rdata == 8'h00)
    else $error("unimplemented register not zero");

  c_ext_fetch: cover property (st.mode == PDM_EXT && o_fetch_valid);
  c_proc_fetch: cover property (st.mode == PDM_PROC && o_fetch_valid);
  c_move: cover property (i_move_periph_to_file ##1 i_move_file_to_periph);
  c_vector: cover property (i_vec_take && i_vec_sel == 2'b11);

endmodule // pdm_memory_map
`default_nettype wire

/* File: bench/pdm_ext_mem.sv */
// External program memory behind address latches, far side of the bus.
// Assumes resolved port levels and the block's three control pins.
`timescale 1ns/1ps
`default_nettype none

module pdm_ext_mem (
  input  wire logic       i_mclk,
  input  wire logic [2:0] i_ctl,
  input  wire logic       i_ctl_oe,
  input  wire logic [7:0] i_lo,
  input  wire logic [7:0] i_hi,
  output logic      [7:0] o_lo,
  output logic      [7:0] o_hi
);
  logic [15:0] addr;
  logic [15:0] last = 16'h0000;
  logic        drive;

  // Word is the address scrambled, so a stale address never passes
  assign drive = i_ctl_oe & ~i_ctl[1];
  // Released lines show the inverse of the last level, never a hold
  assign {o_hi, o_lo} = drive ? (addr ^ 16'hc3ff) : ~last;
  always_ff @(posedge i_mclk) begin
    if (i_ctl_oe && i_ctl[0]) addr <= {i_hi, i_lo};
    last <= {o_hi, o_lo};
  end
endmodule // pdm_ext_mem

`default_nettype wire

/* File: bench/testbench.sv */
// Self-checking bench of the memory map block with external memory.
// Assumes pdm_memory_map, pdm_ext_mem and the defines header.
`timescale 1ns/1ps
`default_nettype none
`include "pdm_defs.svh"

module testbench;
  import pdm_pkg::*;
  logic        i_mclk, i_sys_rst, i_fetch_req, i_pc_load, i_vec_take;
  logic        i_pm_wr, i_dm_rd, i_dm_wr, i_move_periph_to_file;
  logic        i_move_file_to_periph, i_load_periph_bank, i_load_ram_bank;
  logic [1:0]  i_cfg_mode, i_vec_sel;
  logic [15:0] i_pc_value, i_pm_waddr, i_pm_wdata, o_pc, o_fetch_data;
  logic [7:0]  i_dm_addr, i_dm_wdata, i_f_addr, i_per_rdata, m_lo, m_hi;
  logic [7:0]  i_bus_port_low, i_bus_port_high, o_bus_port_low;
  logic [7:0]  o_bus_port_high, o_dm_rdata, o_bank_select_reg, o_per_wdata;
  logic [4:0]  i_p_addr;
  logic [3:0]  i_lit, o_per_bank;
  logic [2:0]  o_bus_control_port, o_per_addr;
  logic        o_fetch_busy, o_fetch_valid, o_code_protect, o_int_pm_ok;
  logic        o_special_ok, o_bus_port_oe, o_bus_control_oe, o_dm_rvalid;
  logic        o_per_we, sd, so;
  int          mismatches = 0;
  int          tests_run = 0;

  // ----------------------------------------
  // Block, far side and pin resolution
  // ----------------------------------------
  pdm_memory_map #(.PM_WORDS(256)) dut (
    .i_mclk, .i_sys_rst, .i_cfg_mode, .i_fetch_req, .i_pc_load,
    .i_pc_value, .i_vec_take, .i_vec_sel, .o_pc, .o_fetch_busy,
    .o_fetch_valid, .o_fetch_data, .o_code_protect, .o_int_pm_ok,
    .o_special_ok, .i_pm_wr, .i_pm_waddr, .i_pm_wdata, .i_bus_port_low,
    .i_bus_port_high, .o_bus_port_low, .o_bus_port_high, .o_bus_port_oe,
    .o_bus_control_port, .o_bus_control_oe, .i_dm_rd, .i_dm_wr,
    .i_dm_addr, .i_dm_wdata, .i_move_periph_to_file,
    .i_move_file_to_periph, .i_p_addr, .i_f_addr, .i_load_periph_bank,
    .i_load_ram_bank, .i_lit, .o_dm_rdata, .o_dm_rvalid,
    .o_bank_select_reg, .i_per_rdata, .o_per_we, .o_per_bank,
    .o_per_addr, .o_per_wdata);
  pdm_ext_mem u_mem (.i_mclk, .i_ctl(o_bus_control_port),
    .i_ctl_oe(o_bus_control_oe), .i_lo(i_bus_port_low),
    .i_hi(i_bus_port_high), .o_lo(m_lo), .o_hi(m_hi));
  assign i_bus_port_low  = o_bus_port_oe ? o_bus_port_low : m_lo;
  assign i_bus_port_high = o_bus_port_oe ? o_bus_port_high : m_hi;
  // Peripheral data carries the bank so a wrong bank shows up
  assign i_per_rdata = {o_bank_select_reg[3:0], 4'h5};

  initial begin
    i_mclk = 1'b0;
    forever #2 i_mclk = ~i_mclk;
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic reset_to(input logic [1:0] m);
    @(posedge i_mclk);
    i_sys_rst <= 1'b1;
    i_cfg_mode <= m;
    repeat (3) @(posedge i_mclk);
    i_sys_rst <= 1'b0;
    @(posedge i_mclk);
    #1;
  endtask
  task automatic load_pc(input logic [15:0] v);
    @(posedge i_mclk);
    i_pc_load <= 1'b1;
    i_pc_value <= v;
    @(posedge i_mclk);
    i_pc_load <= 1'b0;
    #1;
  endtask
  task automatic pmw(input logic [15:0] a, input logic [15:0] d);
    @(posedge i_mclk);
    i_pm_wr <= 1'b1;
    i_pm_waddr <= a;
    i_pm_wdata <= d;
    @(posedge i_mclk);
    i_pm_wr <= 1'b0;
  endtask
  // Counts cycles from the taking edge to valid; notes the read strobe and drive
  task automatic fetch(input int lat, input logic [15:0] exp);
    int n;
    @(posedge i_mclk);
    i_fetch_req <= 1'b1;
    @(posedge i_mclk);
    i_fetch_req <= 1'b0;
    #1;
    n = 1;
    sd = 1'b0;
    so = o_bus_port_oe;
    chk(16'(o_fetch_busy), 16'(lat > 1));
    while (o_fetch_valid !== 1'b1 && n < 8) begin
      @(posedge i_mclk);
      #1;
      n++;
      sd |= (o_bus_control_port === `PDM_CTL_DATA);
      so |= o_bus_port_oe;
    end
    if (o_fetch_valid !== 1'b1) begin
      mismatches++;
      $display("MISMATCH %0t fetch timed out", $time);
      results;
    end
    chk(16'(n), 16'(lat));
    chk(o_fetch_data, exp);
  endtask
  task automatic bank(input logic rb, input logic [3:0] v);
    @(posedge i_mclk);
    i_load_ram_bank <= rb;
    i_load_periph_bank <= ~rb;
    i_lit <= v;
    @(posedge i_mclk);
    {i_load_ram_bank, i_load_periph_bank} <= 2'b00;
    #1;
    chk(16'(rb ? o_bank_select_reg[7:4] : o_bank_select_reg[3:0]),
        16'(v));
  endtask
  task automatic dwr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    i_dm_wr <= 1'b1;
    i_dm_addr <= a;
    i_dm_wdata <= d;
    @(posedge i_mclk);
    i_dm_wr <= 1'b0;
    #1;
  endtask
  // Also checks the bus is quiet just after every data read
  task automatic drd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge i_mclk);
    i_dm_rd <= 1'b1;
    i_dm_addr <= a;
    @(posedge i_mclk);
    i_dm_rd <= 1'b0;
    #1;
    chk(16'(o_dm_rvalid), 16'h0001);
    chk(16'(o_dm_rdata), 16'(exp));
    chk(16'({o_bus_port_oe, o_bus_control_port}), 16'(`PDM_CTL_IDLE));
  endtask
  task automatic mv(input logic pf, input logic [4:0] p, input logic [7:0] f);
    @(posedge i_mclk);
    i_move_periph_to_file <= pf;
    i_move_file_to_periph <= ~pf;
    i_p_addr <= p;
    i_f_addr <= f;
    @(posedge i_mclk);
    {i_move_periph_to_file, i_move_file_to_periph} <= 2'b00;
    #1;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic s_modes;
    for (int m = 0; m < 4; m++) begin
      reset_to(2'(m));
      chk(16'(o_code_protect), 16'(m == PDM_PROT));
      chk(16'(o_int_pm_ok), 16'(m != `PDM_CFG_UNPROG));
      chk(16'(o_special_ok), 16'(m <= PDM_CTRL));
      chk(16'(o_bus_control_oe), 16'(m >= PDM_EXT));
      chk(o_pc, `PDM_RESET_VEC);
      chk(16'(o_bank_select_reg), 16'(`PDM_BSR_RST));
    end
  endtask
  task automatic s_internal;
    reset_to(PDM_CTRL);
    for (int i = 0; i < 2; i++) pmw(16'(i), 16'ha500 + 16'(i));
    pmw(16'h00ff, 16'h7e7e);
    fetch(1, 16'ha500);
    chk(16'(so), 16'h0000);
    fetch(1, 16'ha501);
    load_pc(16'h00ff);
    fetch(1, 16'h7e7e);
    fetch(1, `PDM_UNDEF_WORD);
    load_pc(16'hffff);
    fetch(1, `PDM_UNDEF_WORD);
    chk(o_pc, 16'h0000);
    for (int s = 0; s < 4; s++) begin
      @(posedge i_mclk);
      i_vec_take <= 1'b1;
      i_vec_sel <= 2'(s);
      @(posedge i_mclk);
      i_vec_take <= 1'b0;
      #1;
      chk(o_pc, `PDM_VEC_STEP * 16'(s + 1));
    end
    reset_to(PDM_PROT);
    fetch(1, 16'ha500);
    chk(16'(so), 16'h0000);
  endtask
  task automatic s_external;
    reset_to(PDM_PROC);
    load_pc(16'h0001);
    fetch(3, 16'h0001 ^ 16'hc3ff);
    chk(16'(sd), 16'h0001);
    reset_to(PDM_EXT);
    load_pc(16'h0001);
    fetch(3, 16'ha501);
    chk(16'(sd), 16'h0001);
    load_pc(16'h1234);
    fetch(3, 16'h1234 ^ 16'hc3ff);
  endtask
  task automatic s_data;
    bank(1'b1, 4'h1);
    dwr(8'h25, 8'hc3);
    bank(1'b1, 4'h2);
    dwr(8'h25, 8'h3c);
    drd(8'h25, 8'h3c);
    bank(1'b1, 4'h1);
    drd(8'h25, 8'hc3);
    dwr(8'h1a, 8'h5b);
    bank(1'b1, 4'h3);
    drd(8'h1a, 8'h5b);
    bank(1'b1, 4'h5);
    drd(8'h25, 8'h00);
    drd(8'h18, 8'h00);
    bank(1'b1, 4'h1);
    dwr(`PDM_A_FP0, 8'h25);
    drd(`PDM_A_INDF0, 8'hc3);
    bank(1'b0, 4'h3);
    dwr(8'h12, 8'h5a);
    chk({o_per_we, o_per_bank, o_per_addr, o_per_wdata}, 16'h9a5a);
    mv(1'b1, 5'h12, 8'h30);
    drd(8'h30, 8'h35);
    mv(1'b0, 5'h13, 8'h30);
    chk({o_per_we, o_per_bank, o_per_addr, o_per_wdata}, 16'h9b35);
    reset_to(PDM_CTRL);
    bank(1'b1, 4'h1);
    drd(8'h25, 8'hc3);
    drd(8'h1a, 8'h5b);
  endtask

  initial begin
    // Held from time zero so no check sees the state before reset
    i_sys_rst = 1'b1;
    {i_fetch_req, i_pc_load, i_vec_take, i_pm_wr} = '0;
    {i_dm_rd, i_dm_wr, i_move_periph_to_file, i_move_file_to_periph} = '0;
    {i_load_periph_bank, i_load_ram_bank, i_cfg_mode, i_vec_sel} = '0;
    {i_pc_value, i_pm_waddr, i_pm_wdata, i_dm_addr, i_dm_wdata} = '0;
    {i_f_addr, i_p_addr, i_lit} = '0;
    s_modes();
    s_internal();
    s_external();
    s_data();
    results();
  end
endmodule // testbench

`default_nettype wire
